/* File: design/irqfe_pkg.sv */
package irqfe_pkg;

	// Register geometry
	localparam int           NUM_GROUPS  = 5;
	localparam int           GROUP_BITS  = 16;
	localparam int           PRIO_BITS   = 3;
	localparam int           NUM_SRC     = NUM_GROUPS * GROUP_BITS;

	// Byte offsets on the bus, one 32-bit word each
	localparam logic [7:0]   OFS_PEND0   = 8'h00;
	localparam logic [7:0]   OFS_PERMIT0 = 8'h20;
	localparam logic [7:0]   OFS_EVT_ST  = 8'h40;
	localparam logic [7:0]   OFS_EVT_MSK = 8'h44;
	localparam logic [7:0]   OFS_STEP    = 8'h04;

	// Reset values
	localparam logic [15:0]  RST_PEND    = 16'h0000;
	localparam logic [15:0]  RST_PERMIT  = 16'h0000;
	localparam logic [4:0]   RST_EVT     = 5'h00;
	localparam logic [2:0]   PRIO_OFF    = 3'h0;

	// Implemented bits per group, flag and permit share a layout
	localparam logic [15:0]  IMPL_G0     = 16'h7FFF;
	localparam logic [15:0]  IMPL_G1     = 16'hFFDF;
	localparam logic [15:0]  IMPL_G2     = 16'h601F;
	localparam logic [15:0]  IMPL_G3     = 16'h6000;
	localparam logic [15:0]  IMPL_G4     = 16'h007E;

	// Field positions named by the block
	localparam int           POS_EXT0_PERMIT     = 0;
	localparam int           POS_CAPTURE1_PERMIT = 1;
	localparam int           POS_COMPARE1_PERMIT = 2;
	localparam int           POS_UART_A_RX       = 11;
	localparam int           POS_I2C_SLAVE       = 0;
	localparam int           POS_I2C_MASTER      = 1;
	localparam int           POS_COMPARATOR      = 2;
	localparam int           POS_DMA_CH3_DONE    = 4;
	localparam int           POS_DMA_CH5_DONE    = 13;
	localparam int           POS_RTC_EVENT       = 14;
	localparam int           POS_UART_A_ERROR    = 1;

	// Controller-area-network sources, per group
	localparam logic [15:0]  CAN_G2      = 16'h000C;
	localparam logic [15:0]  CAN_G4      = 16'h0040;

endpackage

/* File: design/irqfe_group.sv */
`timescale 1ns/10ps
module irqfe_group #(
	parameter logic [15:0] IMPL = 16'hFFFF,
	parameter logic [15:0] GATE = 16'hFFFF
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] req_i,
	input  wire logic        wr_pend_i,
	input  wire logic        wr_permit_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [47:0] prio_i,
	output logic      [15:0] pend_o,
	output logic      [15:0] permit_o,
	output logic      [15:0] fwd_o,
	output logic      [2:0]  best_o,
	output logic             new_evt_o
);

	logic [15:0] lane;
	logic [15:0] prio_on;
	logic [15:0] next_pend;
	logic [15:0] next_permit;

	// Byte-lane mask from the bus selects
	assign lane = {{8{sel_i[1]}}, {8{sel_i[0]}}};

	// Per-source priority field, zero means source off
	genvar b;
	generate
		for (b = 0; b < 16; b++) begin : g_prio
			assign prio_on[b] = (prio_i[3*b +: 3] != irqfe_pkg::PRIO_OFF);
		end
	endgenerate

	// Software merge then hardware set, set wins
	always_comb begin
		next_pend = pend_o;
		if (wr_pend_i) begin
			next_pend = (pend_o & ~lane) | (wdata_i & lane);
		end
		next_pend = (next_pend | req_i) & IMPL;
	end

	// Permit bits hold only software writes
	always_comb begin
		next_permit = permit_o;
		if (wr_permit_i) begin
			next_permit = (permit_o & ~lane) | (wdata_i & lane);
		end
		next_permit = next_permit & IMPL;
	end

	// Pending flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_o <= irqfe_pkg::RST_PEND;
		end else begin
			pend_o <= next_pend;
		end
	end

	// Permit flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			permit_o <= irqfe_pkg::RST_PERMIT;
		end else begin
			permit_o <= next_permit;
		end
	end

	// Forwarding needs flag, permit, fitted source and live priority
	assign fwd_o = pend_o & permit_o & GATE & prio_on;

	// A request from a source that was idle
	assign new_evt_o = |(req_i & IMPL & ~pend_o);

	// Highest priority among forwarded sources
	always_comb begin
		best_o = irqfe_pkg::PRIO_OFF;
		for (int i = 0; i < 16; i++) begin
			if (fwd_o[i] && (prio_i[3*i +: 3] > best_o)) begin
				best_o = prio_i[3*i +: 3];
			end
		end
	end

endmodule

/* File: design/irqfe_bank.sv */
// What this block does
// - A flag reads one after its source requests, zero while none pending.
// - A permit bit of one lets its source through; zero blocks it.
// - Unimplemented flag and permit bits read zero and ignore writes.
// - Group 1 flags: comparator bit 2, I2C master bit 1, slave bit 0.
// - Group 3 flags: only RTC bit 14 and DMA 5 bit 13.
// - Group 2 bit 4 flags DMA channel 3 transfer completion.
// - Group 4 bit 1 is UART A error; bit 0 unimplemented.
// - Group 0 permit bit 11 gates UART A receiver.
// - Group 0 permits: compare 1 bit 2, capture 1 bit 1, ext 0 bit 0.
// - Group 1 permits: comparator bit 2, I2C master 1, slave 0.
// - Without the CAN controller its three sources never forward.
// - Priority field zero disables a source; one to seven rank it.
`timescale 1ns/10ps
module irqfe_bank #(
	parameter bit CAN_PRESENT = 1'b1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic [79:0]  src_req_i,
	input  wire logic [239:0] src_prio_i,
	output logic      [79:0]  fwd_o,
	output logic      [2:0]   top_level_o,
	output logic              irq_o
);

	localparam int G = irqfe_pkg::NUM_GROUPS;

	// Implemented layout of every group
	localparam logic [4:0][15:0] IMPL = {
		irqfe_pkg::IMPL_G4,
		irqfe_pkg::IMPL_G3,
		irqfe_pkg::IMPL_G2,
		irqfe_pkg::IMPL_G1,
		irqfe_pkg::IMPL_G0
	};

	// Sources fitted on this variant
	localparam logic [15:0] GATE2 = CAN_PRESENT ? 16'hFFFF :
		~irqfe_pkg::CAN_G2;
	localparam logic [15:0] GATE4 = CAN_PRESENT ? 16'hFFFF :
		~irqfe_pkg::CAN_G4;
	localparam logic [4:0][15:0] GATE = {
		GATE4, 16'hFFFF, GATE2, 16'hFFFF, 16'hFFFF
	};

	logic             req_take;
	logic             wr_take;
	logic [7:0]       adr_word;
	logic [2:0]       grp_idx;
	logic             hit_pend;
	logic             hit_permit;
	logic             hit_evt_st;
	logic             hit_evt_msk;
	logic [4:0]       wr_pend;
	logic [4:0]       wr_permit;
	logic [4:0][15:0] pend;
	logic [4:0][15:0] permit;
	logic [4:0][15:0] fwd;
	logic [4:0][2:0]  best;
	logic [4:0]       new_evt;
	logic [4:0]       evt_status;
	logic [4:0]       evt_mask;
	logic [4:0]       next_evt_status;
	logic [31:0]      next_rdata;
	logic [2:0]       next_top;
	logic [79:0]      fwd_flat;

	// A classic request is taken once, ack follows one edge later
	assign req_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_take  = req_take && wb_we_i;

	// Word-aligned address and group index within a bank
	assign adr_word = {wb_adr_i[7:2], 2'b00};
	assign grp_idx  = wb_adr_i[4:2];

	// Region decode
	assign hit_pend    = (adr_word >= irqfe_pkg::OFS_PEND0) &&
		(adr_word < irqfe_pkg::OFS_PEND0 +
		8'(G) * irqfe_pkg::OFS_STEP);
	assign hit_permit  = (adr_word >= irqfe_pkg::OFS_PERMIT0) &&
		(adr_word < irqfe_pkg::OFS_PERMIT0 +
		8'(G) * irqfe_pkg::OFS_STEP);
	assign hit_evt_st  = (adr_word == irqfe_pkg::OFS_EVT_ST);
	assign hit_evt_msk = (adr_word == irqfe_pkg::OFS_EVT_MSK);

	// Per-group write strobes
	always_comb begin
		wr_pend   = 5'h00;
		wr_permit = 5'h00;
		for (int g = 0; g < G; g++) begin
			if (wr_take && (grp_idx == 3'(g))) begin
				wr_pend[g]   = hit_pend;
				wr_permit[g] = hit_permit;
			end
		end
	end

	// One flag and permit bank per group
	genvar gi;
	generate
		for (gi = 0; gi < G; gi++) begin : g_bank
			irqfe_group #(
				.IMPL (IMPL[gi]),
				.GATE (GATE[gi])
			) u_group (
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.req_i       (src_req_i[16*gi +: 16]),
				.wr_pend_i   (wr_pend[gi]),
				.wr_permit_i (wr_permit[gi]),
				.sel_i       (wb_sel_i[1:0]),
				.wdata_i     (wb_dat_i[15:0]),
				.prio_i      (src_prio_i[48*gi +: 48]),
				.pend_o      (pend[gi]),
				.permit_o    (permit[gi]),
				.fwd_o       (fwd[gi]),
				.best_o      (best[gi]),
				.new_evt_o   (new_evt[gi])
			);
			assign fwd_flat[16*gi +: 16] = fwd[gi];
		end
	endgenerate

	// Read mux, unimplemented and unmapped words read zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (hit_pend) begin
			next_rdata = {16'h0000, pend[grp_idx]};
		end else if (hit_permit) begin
			next_rdata = {16'h0000, permit[grp_idx]};
		end else if (hit_evt_st) begin
			next_rdata = {27'h0, evt_status};
		end else if (hit_evt_msk) begin
			next_rdata = {27'h0, evt_mask};
		end
	end

	// Bus acknowledge, one cycle per request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_take;
		end
	end

	// Read data captured with the acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req_take && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// Event status: new request per group, write one to clear, set wins
	always_comb begin
		next_evt_status = evt_status;
		if (wr_take && hit_evt_st && wb_sel_i[0]) begin
			next_evt_status = evt_status & ~wb_dat_i[4:0];
		end
		next_evt_status = next_evt_status | new_evt;
	end

	// Event status register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status <= irqfe_pkg::RST_EVT;
		end else begin
			evt_status <= next_evt_status;
		end
	end

	// Event mask register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask <= irqfe_pkg::RST_EVT;
		end else if (wr_take && hit_evt_msk && wb_sel_i[0]) begin
			evt_mask <= wb_dat_i[4:0];
		end
	end

	// Interrupt line, high while an unmasked event bit stands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_evt_status & evt_mask);
		end
	end

	// Highest live priority across all groups
	always_comb begin
		next_top = irqfe_pkg::PRIO_OFF;
		for (int g = 0; g < G; g++) begin
			if (best[g] > next_top) begin
				next_top = best[g];
			end
		end
	end

	// Forwarded requests towards priority resolution
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_o       <= 80'h0;
			top_level_o <= irqfe_pkg::PRIO_OFF;
		end else begin
			fwd_o       <= fwd_flat;
			top_level_o <= next_top;
		end
	end

endmodule

/* File: bench/irqfe_bank_monitor.sv */
`timescale 1ns/10ps
module irqfe_bank_monitor #(
	parameter bit CAN_PRESENT = 1'b1
) (
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire logic         wb_cyc_i,
	input wire logic         wb_stb_i,
	input wire logic         wb_we_i,
	input wire logic [7:0]   wb_adr_i,
	input wire logic [3:0]   wb_sel_i,
	input wire logic [31:0]  wb_dat_i,
	input wire logic [31:0]  wb_dat_o,
	input wire logic         wb_ack_o,
	input wire logic [79:0]  src_req_i,
	input wire logic [239:0] src_prio_i,
	input wire logic [79:0]  fwd_o,
	input wire logic [2:0]   top_level_o,
	input wire logic         irq_o
);
	// Implemented source bits, group 4 at the top
	localparam logic [79:0] IMPL = {irqfe_pkg::IMPL_G4, irqfe_pkg::IMPL_G3,
		irqfe_pkg::IMPL_G2, irqfe_pkg::IMPL_G1, irqfe_pkg::IMPL_G0};
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Request waiting for its answer
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_resp_a: assert property (bus_req |=> wb_ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	rd_upper_a: assert property (wb_ack_o && !wb_we_i |->
		wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
	fwd_impl_a: assert property ((fwd_o & ~IMPL) == 80'h0)
		else $error("absent source forwarded");
	fwd_prio_a: assert property (fwd_o[11] |->
		$past(src_prio_i[35:33]) != 3'h0) else $error("level zero forwarded");
	top_idle_a: assert property ((fwd_o == 80'h0) ==
		(top_level_o == 3'h0)) else $error("level and forward disagree");
	can_gate_a: assert property (CAN_PRESENT ||
		(fwd_o[35:34] == 2'h0 && !fwd_o[70])) else $error("CAN forwarded");
	reset_out_a: assert property ($fell(rst_i) |->
		fwd_o == 80'h0 && !irq_o && !wb_ack_o) else $error("reset not clean");
endmodule

bind irqfe_bank irqfe_bank_monitor #(.CAN_PRESENT(CAN_PRESENT)) i_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.src_req_i(src_req_i), .src_prio_i(src_prio_i), .fwd_o(fwd_o),
	.top_level_o(top_level_o), .irq_o(irq_o));

/* File: bench/irqfe_src_model.sv */
`timescale 1ns/10ps
module irqfe_src_model (
	input  wire logic         clk_i,
	output logic      [79:0]  src_req_o,
	output logic      [239:0] src_prio_o
);
	// Sources idle, all levels off
	initial begin
		src_req_o = 80'h0;
		src_prio_o = 240'h0;
	end
	// One-cycle request from source n
	task automatic pulse(input int n);
		@(posedge clk_i);
		src_req_o[n] <= 1'b1;
		@(posedge clk_i);
		src_req_o[n] <= 1'b0;
	endtask
	// Priority level of source n
	task automatic set_prio(input int n, input logic [2:0] p);
		@(posedge clk_i);
		src_prio_o[3*n +: 3] <= p;
	endtask
endmodule

/* File: bench/irqfe_bank_tb.sv */
`timescale 1ns/10ps
module irqfe_bank_tb;
	logic          clk_i;
	logic          rst_i;
	logic          cyc;
	logic          stb;
	logic          we;
	logic          ack;
	logic          irq;
	logic [7:0]    adr;
	logic [3:0]    sel;
	logic [79:0]   fwd_nc;
	logic [31:0]   wdat;
	logic [31:0]   dout;
	logic [31:0]   rdat;
	logic [79:0]   req;
	logic [79:0]   fwd;
	logic [239:0]  prio;
	logic [2:0]    top;
	logic [15:0]   impl [5];
	int            src [4];
	int            bad_count;
	int            n_tests;
	irqfe_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .src_req_i(req),
		.src_prio_i(prio), .fwd_o(fwd), .top_level_o(top), .irq_o(irq));
	// Variant without the CAN controller, same bus and sources
	irqfe_bank #(.CAN_PRESENT(1'b0)) i_dut_nocan (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(),
		.wb_ack_o(), .src_req_i(req), .src_prio_i(prio), .fwd_o(fwd_nc),
		.top_level_o(), .irq_o());
	irqfe_src_model i_src (.clk_i(clk_i), .src_req_o(req), .src_prio_o(prio));
	// Clock, 40 ns period
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task check(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One classic bus cycle, held until ack is sampled
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string s);
		xfer(1'b0, a, 32'h0);
		check(rdat, e, s);
	endtask
	task complete_run;
		$display("%0d checks, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000;
		bad_count++;
		complete_run;
	end
	initial begin
		impl = '{irqfe_pkg::IMPL_G0, irqfe_pkg::IMPL_G1, irqfe_pkg::IMPL_G2,
			irqfe_pkg::IMPL_G3, irqfe_pkg::IMPL_G4};
		src = '{18, 36, 62, 65};
		{rst_i, cyc, stb, we, adr, wdat} = {3'h4, 41'h0};
		sel = 4'hF;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int g = 0; g < 5; g++) begin
			rd(8'h00 + 8'(4 * g), 32'h0, "flag reset");
			rd(8'h20 + 8'(4 * g), 32'h0, "permit reset");
			xfer(1'b1, 8'h00 + 8'(4 * g), 32'hFFFFFFFF);
			xfer(1'b1, 8'h20 + 8'(4 * g), 32'hFFFFFFFF);
			rd(8'h00 + 8'(4 * g), {16'h0, impl[g]}, "flag bits");
			rd(8'h20 + 8'(4 * g), {16'h0, impl[g]}, "permit bits");
			xfer(1'b1, 8'h00 + 8'(4 * g), 32'h0);
			xfer(1'b1, 8'h20 + 8'(4 * g), 32'h0);
			rd(8'h00 + 8'(4 * g), 32'h0, "flag clear");
		end
		// Only the selected byte lane takes the write
		sel <= 4'h2;
		xfer(1'b1, 8'h20, 32'hFFFF);
		sel <= 4'hF;
		rd(8'h20, {16'h0, irqfe_pkg::IMPL_G0 & 16'hFF00}, "upper lane");
		xfer(1'b1, 8'h20, 32'h0);
		$display("layout test done");
		foreach (src[k]) begin
			i_src.pulse(src[k]);
			rd(8'(4 * (src[k] / 16)), 32'h1 << (src[k] % 16), "named flag");
			xfer(1'b1, 8'(4 * (src[k] / 16)), 32'h0);
		end
		xfer(1'b1, 8'h40, 32'h1F);
		$display("source test done");
		i_src.set_prio(11, 3'h5);
		xfer(1'b1, 8'h20, 32'h0800);
		i_src.pulse(11);
		repeat (2) @(posedge clk_i);
		check(fwd[11], 1'b1, "forward");
		check(top, 3'h5, "level");
		xfer(1'b1, 8'h20, 32'h0);
		repeat (2) @(posedge clk_i);
		check(fwd[11], 1'b0, "blocked");
		i_src.set_prio(11, 3'h0);
		xfer(1'b1, 8'h20, 32'h0800);
		repeat (2) @(posedge clk_i);
		check(fwd[11], 1'b0, "level off");
		i_src.set_prio(11, 3'h7);
		repeat (2) @(posedge clk_i);
		check(top, 3'h7, "top level");
		$display("forward test done");
		// CAN sources forward only on the fitted variant
		i_src.set_prio(34, 3'h1);
		i_src.set_prio(35, 3'h1);
		i_src.set_prio(70, 3'h1);
		xfer(1'b1, 8'h28, 32'h000C);
		xfer(1'b1, 8'h30, 32'h0040);
		xfer(1'b1, 8'h08, 32'h000C);
		xfer(1'b1, 8'h10, 32'h0040);
		repeat (2) @(posedge clk_i);
		check({fwd[70], fwd[35:34]}, 3'h7, "CAN fitted");
		check({fwd_nc[70], fwd_nc[35:34]}, 3'h0, "CAN absent");
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h10, 32'h0);
		$display("variant test done");
		// Drop the group 0 event left by the forward test
		xfer(1'b1, 8'h40, 32'h1F);
		xfer(1'b1, 8'h44, 32'h2);
		i_src.pulse(16);
		@(posedge clk_i);
		check(irq, 1'b1, "irq raised");
		rd(8'h40, 32'h2, "event status");
		xfer(1'b1, 8'h40, 32'h2);
		@(posedge clk_i);
		check(irq, 1'b0, "irq cleared");
		xfer(1'b1, 8'h44, 32'h0);
		xfer(1'b1, 8'h04, 32'h0);
		i_src.pulse(16);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0, "irq masked");
		xfer(1'b1, 8'h80, 32'hFFFF);
		rd(8'h80, 32'h0, "unmapped");
		$display("interrupt test done");
		complete_run;
	end
endmodule
